// ### ext_status_cfg.v
// Extended read status/config register with serial command front end.
// Assumes host drives sck, ce_n and io pins asynchronously to sys_clk.
`include "ext_status_regs.vh"
`timescale 1ns/10ps
module ext_status_cfg (
  sys_clk,
  rst,
  clk_en,
  sck,
  ce_n,
  io_in,
  io_out,
  io_oe_n,
  quad_command_mode,
  dummy_field,
  status_busy,
  status_locked,
  soft_reset,
  op_done,
  op_kind,
  op_fail,
  op_fail_erase_phase,
  op_protected,
  nv_write_req,
  nv_drive_strength,
  drive_strength,
  ext_reg_value,
  read_dummy_cycles,
  read_cmd_valid,
  read_cmd_rejected
);
  input  wire       sys_clk;
  input  wire       rst;
  input  wire       clk_en;
  input  wire       sck;
  input  wire       ce_n;
  input  wire [3:0] io_in;
  output reg  [3:0] io_out;
  output reg  [3:0] io_oe_n;
  input  wire       quad_command_mode;
  input  wire [3:0] dummy_field;
  input  wire       status_busy;
  input  wire       status_locked;
  input  wire       soft_reset;
  input  wire       op_done;
  input  wire [2:0] op_kind;
  input  wire       op_fail;
  input  wire       op_fail_erase_phase;
  input  wire       op_protected;
  output reg        nv_write_req;
  output reg  [2:0] nv_drive_strength;
  output wire [2:0] drive_strength;
  output wire [7:0] ext_reg_value;
  output reg  [3:0] read_dummy_cycles;
  output reg        read_cmd_valid;
  output reg        read_cmd_rejected;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 5'b00001;
  localparam ST_CMD  = 5'b00010;
  localparam ST_DATA = 5'b00100;
  localparam ST_OUT  = 5'b01000;
  localparam ST_DONE = 5'b10000;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [5:0] pins_sync;
  wire       sck_s;
  wire       ce_n_s;
  wire [3:0] io_s;

  link_sync #(.W(6)) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in ({sck, ~ce_n, io_in}),
    .sync_out (pins_sync)
  );

  assign sck_s  = pins_sync[5];
  // Select travels inverted so the synchroniser reset reads as deselected
  assign ce_n_s = ~pins_sync[4];
  assign io_s   = pins_sync[3:0];

  // ----------------------------------------------------------------
  // Edge detection and shifting
  // ----------------------------------------------------------------
  reg        sck_d_reg;
  reg [4:0]  state_reg;
  reg [7:0]  shift_reg;
  reg [3:0]  bit_cnt_reg;
  reg [7:0]  cmd_reg;
  reg [2:0]  vol_drive_reg;
  reg        rsvd_reg;
  reg [7:0]  out_reg;
  wire       sck_rise;
  wire       sck_fall;
  wire [2:0] err_flags;
  wire [3:0] step;
  wire [7:0] next_shift;
  wire       byte_done;

  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;
  // Quad mode moves a nibble per edge
  assign step       = quad_command_mode ? 4'h4 : 4'h1;
  assign next_shift = quad_command_mode ? {shift_reg[3:0], io_s} : {shift_reg[6:0], io_s[0]};
  assign byte_done  = (bit_cnt_reg + step) == 4'h8;

  // ----------------------------------------------------------------
  // Default and programmed dummy count lookup
  // ----------------------------------------------------------------
  function [3:0] default_dummy;
    input [7:0] cmd;
    input       quad;
    begin
      if (cmd == `CMD_DUAL_IO || cmd == `CMD_DUAL_IO_DTR) begin
        default_dummy = `DUMMY_DUAL_IO;
      end else if (cmd == `CMD_QUAD_IO || cmd == `CMD_QUAD_IO_DTR) begin
        default_dummy = `DUMMY_QUAD;
      end else if ((cmd == `CMD_FAST_READ || cmd == `CMD_FAST_READ_DTR) && quad) begin
        default_dummy = `DUMMY_QUAD;
      end else begin
        default_dummy = `DUMMY_SINGLE;
      end
    end
  endfunction

  function is_read_cmd;
    input [7:0] cmd;
    begin
      is_read_cmd = (cmd == `CMD_FAST_READ) || (cmd == `CMD_FAST_READ_DTR) ||
                    (cmd == `CMD_DUAL_OUT) || (cmd == `CMD_DUAL_IO) ||
                    (cmd == `CMD_DUAL_IO_DTR) || (cmd == `CMD_QUAD_OUT) ||
                    (cmd == `CMD_QUAD_IO) || (cmd == `CMD_QUAD_IO_DTR) ||
                    (cmd == `CMD_READ_UID) || (cmd == `CMD_READ_SFDP) ||
                    (cmd == `CMD_INFO_ROW_READ);
    end
  endfunction

  // ----------------------------------------------------------------
  // Error flag tracker
  // ----------------------------------------------------------------
  wire clear_pulse;

  assign clear_pulse = (state_reg == ST_CMD) && sck_rise && byte_done &&
                       (next_shift == `CMD_CLEAR_EXT);

  error_flags u_err (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .clk_en              (clk_en),
    .op_done             (op_done),
    .op_kind             (op_kind),
    .op_fail             (op_fail),
    .op_fail_erase_phase (op_fail_erase_phase),
    .op_protected        (op_protected),
    .status_locked       (status_locked),
    .soft_reset          (soft_reset),
    .clear_cmd           (clear_pulse),
    .flags               (err_flags)
  );

  // Layout of the readable register
  assign ext_reg_value  = {vol_drive_reg, rsvd_reg, err_flags, status_busy};
  assign drive_strength = vol_drive_reg;

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sck_d_reg         <= 1'b0;
      state_reg         <= ST_IDLE;
      shift_reg         <= 8'h00;
      bit_cnt_reg       <= 4'h0;
      cmd_reg           <= 8'h00;
      vol_drive_reg     <= `EXT_DRIVE_RESET;
      rsvd_reg          <= 1'b1;
      out_reg           <= 8'h00;
      io_out            <= 4'h0;
      io_oe_n           <= 4'hF;
      nv_write_req      <= 1'b0;
      nv_drive_strength <= `EXT_DRIVE_RESET;
      read_dummy_cycles <= `DUMMY_SINGLE;
      read_cmd_valid    <= 1'b0;
      read_cmd_rejected <= 1'b0;
    end else if (clk_en) begin
      sck_d_reg         <= sck_s;
      nv_write_req      <= 1'b0;
      read_cmd_valid    <= 1'b0;
      read_cmd_rejected <= 1'b0;
      if (soft_reset) begin
        vol_drive_reg <= `EXT_DRIVE_RESET;
      end
      if (ce_n_s) begin
        // Frame ends: release lines, return to idle
        state_reg   <= ST_IDLE;
        bit_cnt_reg <= 4'h0;
        io_oe_n     <= 4'hF;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            state_reg   <= ST_CMD;
            bit_cnt_reg <= 4'h0;
          end
          ST_CMD: begin
            if (sck_rise) begin
              shift_reg   <= next_shift;
              bit_cnt_reg <= bit_cnt_reg + step;
              if (byte_done) begin
                cmd_reg     <= next_shift;
                bit_cnt_reg <= 4'h0;
                // Later commands run regardless of error flags
                if (next_shift == `CMD_SET_EXT_NV || next_shift == `CMD_SET_EXT_V) begin
                  state_reg <= ST_DATA;
                end else if (next_shift == `CMD_READ_EXT) begin
                  state_reg <= ST_OUT;
                  out_reg   <= ext_reg_value;
                end else if (is_read_cmd(next_shift)) begin
                  state_reg <= ST_DONE;
                  if (next_shift == `CMD_DUAL_IO_DTR && quad_command_mode) begin
                    read_cmd_rejected <= 1'b1;
                  end else begin
                    read_cmd_valid    <= 1'b1;
                    read_dummy_cycles <= (dummy_field == 4'h0) ?
                                         default_dummy(next_shift, quad_command_mode) : dummy_field;
                  end
                end else begin
                  state_reg <= ST_DONE;
                end
              end
            end
          end
          ST_DATA: begin
            if (sck_rise) begin
              shift_reg   <= next_shift;
              bit_cnt_reg <= bit_cnt_reg + step;
              if (byte_done) begin
                state_reg <= ST_DONE;
                // Low five data bits discarded
                if (cmd_reg == `CMD_SET_EXT_NV) begin
                  nv_write_req      <= 1'b1;
                  nv_drive_strength <= next_shift[`EXT_DRIVE_MSB:`EXT_DRIVE_LSB];
                end else begin
                  vol_drive_reg <= next_shift[`EXT_DRIVE_MSB:`EXT_DRIVE_LSB];
                end
              end
            end
          end
          ST_OUT: begin
            // Output changes on falling edge; wraps the byte
            if (sck_fall) begin
              io_oe_n <= quad_command_mode ? 4'h0 : 4'hD;
              if (quad_command_mode) begin
                io_out  <= out_reg[7:4];
                out_reg <= {out_reg[3:0], out_reg[7:4]};
              end else begin
                io_out  <= {2'b00, out_reg[7], 1'b0};
                out_reg <= {out_reg[6:0], out_reg[7]};
              end
            end
          end
          ST_DONE: begin
            // One command per frame; later bytes are ignored
            state_reg <= ST_DONE;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ### ext_status_regs.vh
// Constants for the extended read status/config block of a serial NOR flash.
// Assumes inclusion by the link front end, the error tracker and the top level.
// Functional notes
// - Default dummy counts: 8 single/dual-out/quad-out SPI, 6 QUAD_COMMAND_MODE and quad I/O, 4 dual I/O.
// - Unique ID, discovery parameter and info row reads use the single-line default 8.
// - Dual I/O DTR read is accepted only in SPI mode, never in quad mode.
// - Register layout: drive strength 7:5, reserved 4, erase 3, program 2, protect 1, busy 0.
// - Low four status bits read-only; set-extended-parameter writes leave them unchanged.
// - 85h writes the non-volatile copy, 83h the volatile copy of drive strength.
// - Drive codes 001..111 map to strengths; 000 and 100 reserved; reset upper nibble ones.
// - Bit 0 mirrors the status register busy bit exactly.
// - Protection error set on erase or program of protected or locked areas.
// - Program error set on program, function or non-volatile write failure or protection.
// - Erase error set on erase or non-volatile update failure or protected erase.
// - Page program to protected or suspended area sets program and protection errors.
// - Info row program to locked region sets program and protection errors.
// - Non-volatile update erase-phase failure sets erase error, program-phase sets program.
// - Status write while locked by write-disable and low protect pin sets protect and erase.
// - Protected sector/block/info-row erase sets erase and protect; chip erase sets neither.
// - OTP function bits only go 0 to 1; writing 0 is ignored without error.
// - Read-only bits ignore register write data and raise no error.
// - Error flags stay set until the clear command or a hardware or software reset.
// - Commands keep executing normally while error flags are set.
// - Dummy field 1..15 gives explicit cycles; zero selects per-command defaults.
`ifndef EXT_STATUS_REGS_VH
`define EXT_STATUS_REGS_VH

// ----------------------------------------------------------------
// Extended register fields
// ----------------------------------------------------------------
`define EXT_DRIVE_MSB       7
`define EXT_DRIVE_LSB       5
`define EXT_RSVD_BIT        4
`define EXT_ERASE_ERR_BIT   3
`define EXT_PROG_ERR_BIT    2
`define EXT_PROT_ERR_BIT    1
`define EXT_BUSY_BIT        0
`define EXT_UPPER_RESET     4'hF
`define EXT_DRIVE_RESET     3'h7

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_SET_EXT_NV      8'h85
`define CMD_SET_EXT_V       8'h83
`define CMD_READ_EXT        8'h81
`define CMD_CLEAR_EXT       8'h82
`define CMD_FAST_READ       8'h0B
`define CMD_FAST_READ_DTR   8'h0D
`define CMD_DUAL_OUT        8'h3B
`define CMD_DUAL_IO         8'hBB
`define CMD_DUAL_IO_DTR     8'hBD
`define CMD_QUAD_OUT        8'h6B
`define CMD_QUAD_IO         8'hEB
`define CMD_QUAD_IO_DTR     8'hED
`define CMD_READ_UID        8'h4B
`define CMD_READ_SFDP       8'h5A
`define CMD_INFO_ROW_READ   8'h68

// ----------------------------------------------------------------
// Default dummy counts
// ----------------------------------------------------------------
`define DUMMY_SINGLE        4'h8
`define DUMMY_QUAD          4'h6
`define DUMMY_DUAL_IO       4'h4

// ----------------------------------------------------------------
// Operation outcome codes from the array sequencer
// ----------------------------------------------------------------
`define OP_PAGE_PROG        3'h1
`define OP_INFO_PROG        3'h2
`define OP_NV_UPDATE        3'h3
`define OP_FUNC_WRITE       3'h4
`define OP_STATUS_WRITE     3'h5
`define OP_AREA_ERASE       3'h6
`define OP_CHIP_ERASE       3'h7

`endif

// ### link_sync.v
// Two-stage synchroniser for the serial link pins.
// Assumes pins are asynchronous to sys_clk.
`timescale 1ns/10ps
module link_sync (
  sys_clk,
  rst,
  clk_en,
  async_in,
  sync_out
);
  parameter W = 1;
  input  wire         sys_clk;
  input  wire         rst;
  input  wire         clk_en;
  input  wire [W-1:0] async_in;
  output reg  [W-1:0] sync_out;

  reg [W-1:0] stage1_reg;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= {W{1'b0}};
      sync_out   <= {W{1'b0}};
    end else if (clk_en) begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule

// ### error_flags.v
// Sticky error flags of the extended register.
// Assumes a one-cycle outcome pulse from the array sequencer.
`include "ext_status_regs.vh"
`timescale 1ns/10ps
module error_flags (
  sys_clk,
  rst,
  clk_en,
  op_done,
  op_kind,
  op_fail,
  op_fail_erase_phase,
  op_protected,
  status_locked,
  soft_reset,
  clear_cmd,
  flags
);
  input  wire       sys_clk;
  input  wire       rst;
  input  wire       clk_en;
  input  wire       op_done;
  input  wire [2:0] op_kind;
  input  wire       op_fail;
  input  wire       op_fail_erase_phase;
  input  wire       op_protected;
  input  wire       status_locked;
  input  wire       soft_reset;
  input  wire       clear_cmd;
  output reg  [2:0] flags;

  // flags = {erase, program, protection}
  reg set_erase;
  reg set_prog;
  reg set_prot;

  always @* begin
    set_erase = 1'b0;
    set_prog  = 1'b0;
    set_prot  = 1'b0;
    if (op_done) begin
      case (op_kind)
        `OP_PAGE_PROG, `OP_INFO_PROG: begin
          set_prog = op_fail | op_protected;
          set_prot = op_protected;
        end
        `OP_NV_UPDATE: begin
          set_erase = op_fail & op_fail_erase_phase;
          set_prog  = op_fail & ~op_fail_erase_phase;
        end
        `OP_FUNC_WRITE: begin
          set_prog = op_fail;
        end
        `OP_STATUS_WRITE: begin
          set_erase = status_locked | (op_fail & op_fail_erase_phase);
          set_prog  = ~status_locked & op_fail & ~op_fail_erase_phase;
          set_prot  = status_locked;
        end
        `OP_AREA_ERASE: begin
          set_erase = op_fail | op_protected;
          set_prot  = op_protected;
        end
        `OP_CHIP_ERASE: begin
          set_erase = op_fail & ~op_protected;
        end
        default: begin
          set_erase = 1'b0;
        end
      endcase
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags <= 3'h0;
    end else if (clk_en) begin
      // Set wins over clear
      flags <= ((clear_cmd | soft_reset) ? 3'h0 : flags) | {set_erase, set_prog, set_prot};
    end
  end
endmodule

// ### ext_status_cfg_properties.sv
// Port-level checker for the extended status/config block.
// Assumes binding onto ext_status_cfg; one sys_clk domain.
`timescale 1ns/10ps
module ext_status_cfg_properties (
  input logic       sys_clk,
  input logic       rst,
  input logic       ce_n,
  input logic       quad_command_mode,
  input logic [3:0] dummy_field,
  input logic       status_busy,
  input logic       status_locked,
  input logic       soft_reset,
  input logic       op_done,
  input logic [2:0] op_kind,
  input logic       op_protected,
  input logic       nv_write_req,
  input logic [2:0] drive_strength,
  input logic [7:0] ext_reg_value,
  input logic [3:0] read_dummy_cycles,
  input logic       read_cmd_valid,
  input logic       read_cmd_rejected
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_busy_mirror;
    ext_reg_value[0] == status_busy;
  endproperty
  a_busy_mirror: assert property (p_busy_mirror)
    else $error("busy bit differs from status busy");
  property p_upper_layout;
    ext_reg_value[7:4] == {drive_strength, 1'b1};
  endproperty
  a_upper_layout: assert property (p_upper_layout)
    else $error("drive or reserved bits misplaced");
  property p_page_prot;
    op_done && op_kind == 3'h1 && op_protected |=> ext_reg_value[2:1] == 2'b11;
  endproperty
  a_page_prot: assert property (p_page_prot)
    else $error("protected page program did not set both flags");
  property p_status_lock;
    op_done && op_kind == 3'h5 && status_locked |=> ext_reg_value[3] && ext_reg_value[1];
  endproperty
  a_status_lock: assert property (p_status_lock)
    else $error("locked status write did not set flags");
  property p_chip_erase;
    op_done && op_kind == 3'h7 && !soft_reset |=> $stable(ext_reg_value[3:1]);
  endproperty
  a_chip_erase: assert property (p_chip_erase)
    else $error("chip erase changed error flags");
  property p_sticky;
    $fell(ext_reg_value[3]) || $fell(ext_reg_value[2]) || $fell(ext_reg_value[1])
      |-> soft_reset || $past(soft_reset) || !ce_n;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error flag cleared without clear or reset");
  property p_reject;
    read_cmd_rejected |-> quad_command_mode && !read_cmd_valid;
  endproperty
  a_reject: assert property (p_reject)
    else $error("read refused outside quad mode");
  property p_dummy_explicit;
    read_cmd_valid && dummy_field != 4'h0 |-> ##[0:1] read_dummy_cycles == dummy_field;
  endproperty
  a_dummy_explicit: assert property (p_dummy_explicit)
    else $error("explicit dummy count not applied");
  property p_nv_keeps_volatile;
    nv_write_req |=> $stable(drive_strength) && !nv_write_req;
  endproperty
  a_nv_keeps_volatile: assert property (p_nv_keeps_volatile)
    else $error("non-volatile write disturbed volatile drive");
endmodule

bind ext_status_cfg ext_status_cfg_properties i_ext_status_cfg_properties (
  .sys_clk(sys_clk), .rst(rst), .ce_n(ce_n), .quad_command_mode(quad_command_mode),
  .dummy_field(dummy_field), .status_busy(status_busy), .status_locked(status_locked),
  .soft_reset(soft_reset), .op_done(op_done), .op_kind(op_kind), .op_protected(op_protected),
  .nv_write_req(nv_write_req), .drive_strength(drive_strength), .ext_reg_value(ext_reg_value),
  .read_dummy_cycles(read_dummy_cycles), .read_cmd_valid(read_cmd_valid),
  .read_cmd_rejected(read_cmd_rejected));

// ### host_link_model.sv
// Host-side serial link model: command, data and register read frames.
// Assumes the device samples the link pins with its own clock.
`timescale 1ns/10ps
module host_link_model (
  output logic       sck,
  output logic       ce_n,
  output logic [3:0] io_in,
  input  logic [3:0] io_out,
  input  logic [3:0] io_oe_n
);
  // ------------------------------------------------------------
  // Frame tasks
  // ------------------------------------------------------------
  initial begin
    sck = 1'b0;
    ce_n = 1'b1;
    io_in = 4'h5;
  end

  task automatic shift_out(input logic [7:0] b, input logic quad);
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      io_in = quad ? b[7-4*i -: 4] : {~io_in[3:1], b[7-i]};
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
  endtask

  task automatic frame(input logic [7:0] cmd, input logic quad, input logic wr, input logic [7:0] data,
                       input logic rd, output logic [7:0] rd_byte, output logic [3:0] rd_oe);
    rd_byte = 8'h00;
    rd_oe = 4'hF;
    ce_n = 1'b0;
    #100;
    shift_out(cmd, quad);
    if (wr)
      shift_out(data, quad);
    for (int i = 0; i < 8; i++) begin
      if (rd) begin
        io_in = ~io_in;
        #80 sck = 1'b1;
        rd_byte[7-i] = io_out[1];
        rd_oe = io_oe_n;
        #80 sck = 1'b0;
      end
    end
    io_in = ~io_in;
    #100 ce_n = 1'b1;
    #100;
  endtask
endmodule

// ### ext_status_cfg_tb.sv
// Self-checking bench for the extended status/config block.
// Assumes host_link_model drives the link and the checker is bound.
`timescale 1ns/10ps
module ext_status_cfg_tb;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic       sys_clk, rst, clk_en, sck, ce_n, quad_command_mode, status_busy, status_locked, soft_reset;
  logic       op_done, op_fail, op_fail_erase_phase, op_protected, nv_write_req;
  logic       read_cmd_valid, read_cmd_rejected;
  logic [3:0] io_in, io_out, io_oe_n, dummy_field, read_dummy_cycles, oe;
  logic [2:0] op_kind, nv_drive_strength, drive_strength;
  logic [7:0] ext_reg_value, rb;
  int         n_fail, n_checks, n_valid, n_rej, n_nv;

  ext_status_cfg i_ext_status_cfg (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .sck(sck), .ce_n(ce_n),
    .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .quad_command_mode(quad_command_mode),
    .dummy_field(dummy_field), .status_busy(status_busy), .status_locked(status_locked),
    .soft_reset(soft_reset), .op_done(op_done), .op_kind(op_kind), .op_fail(op_fail),
    .op_fail_erase_phase(op_fail_erase_phase), .op_protected(op_protected), .nv_write_req(nv_write_req),
    .nv_drive_strength(nv_drive_strength), .drive_strength(drive_strength), .ext_reg_value(ext_reg_value),
    .read_dummy_cycles(read_dummy_cycles), .read_cmd_valid(read_cmd_valid),
    .read_cmd_rejected(read_cmd_rejected));
  host_link_model i_host_link_model (.sck(sck), .ce_n(ce_n), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    n_valid += (read_cmd_valid === 1'b1);
    n_rej += (read_cmd_rejected === 1'b1);
    n_nv += (nv_write_req === 1'b1);
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic send(input logic [7:0] cmd, input logic wr, input logic [7:0] data, input logic rd);
    i_host_link_model.frame(cmd, quad_command_mode, wr, data, rd, rb, oe);
  endtask

  task automatic run_op(input logic [2:0] k, input logic f, input logic ep, input logic pr, input logic lk,
                        input logic [2:0] e);
    tick;
    soft_reset = 1'b1;
    tick;
    {soft_reset, status_locked, op_kind, op_fail, op_fail_erase_phase, op_protected} = {1'b0, lk, k, f, ep, pr};
    op_done = 1'b1;
    tick;
    {op_done, op_fail, op_fail_erase_phase, op_protected} = 4'h0;
    tick;
    status_locked = 1'b0;
    chk("error_flags", {5'h0, ext_reg_value[3:1]}, {5'h0, e});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_and_busy;
    chk("ext_reset", ext_reg_value, 8'hF0);
    chk("oe_idle", {4'h0, io_oe_n}, 8'h0F);
    status_busy = 1'b1;
    tick;
    chk("busy_set", ext_reg_value, 8'hF1);
    status_busy = 1'b0;
    tick;
    chk("busy_clr", ext_reg_value, 8'hF0);
  endtask

  task automatic t_param_writes;
    int v;
    send(8'h83, 1'b1, 8'h2F, 1'b0);
    chk("vol_drive", {5'h0, drive_strength}, 8'h01);
    chk("ext_after_vol", ext_reg_value, 8'h30);
    v = n_nv;
    send(8'h85, 1'b1, 8'hC0, 1'b0);
    chk("nv_req", 8'(n_nv - v), 8'h01);
    chk("nv_drive", {5'h0, nv_drive_strength}, 8'h06);
    chk("vol_kept", {5'h0, drive_strength}, 8'h01);
  endtask

  task automatic t_errors;
    run_op(3'h1, 1'b1, 1'b0, 1'b0, 1'b0, 3'b010);
    run_op(3'h1, 1'b0, 1'b0, 1'b1, 1'b0, 3'b011);
    run_op(3'h2, 1'b0, 1'b0, 1'b1, 1'b0, 3'b011);
    run_op(3'h3, 1'b1, 1'b1, 1'b0, 1'b0, 3'b100);
    run_op(3'h3, 1'b1, 1'b0, 1'b0, 1'b0, 3'b010);
    run_op(3'h4, 1'b1, 1'b0, 1'b0, 1'b0, 3'b010);
    run_op(3'h5, 1'b0, 1'b0, 1'b0, 1'b1, 3'b101);
    run_op(3'h6, 1'b0, 1'b0, 1'b1, 1'b0, 3'b101);
    run_op(3'h6, 1'b1, 1'b0, 1'b0, 1'b0, 3'b100);
    run_op(3'h7, 1'b0, 1'b0, 1'b1, 1'b0, 3'b000);
    run_op(3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 3'b000);
    {soft_reset, op_done, op_kind, op_fail} = {1'b1, 1'b1, 3'h1, 1'b1};
    tick;
    {soft_reset, op_done, op_fail} = 3'h0;
    chk("set_beats_clear", {5'h0, ext_reg_value[3:1]}, 8'h02);
    chk("drive_soft_reset", {5'h0, drive_strength}, 8'h07);
  endtask

  task automatic t_sticky_clear;
    run_op(3'h1, 1'b1, 1'b0, 1'b0, 1'b0, 3'b010);
    {op_kind, op_done} = {3'h6, 1'b1};
    tick;
    op_done = 1'b0;
    tick;
    chk("sticky", ext_reg_value, 8'hF4);
    {clk_en, soft_reset} = 2'b01;
    tick;
    {clk_en, soft_reset} = 2'b10;
    chk("frozen", ext_reg_value, 8'hF4);
    send(8'h81, 1'b0, 8'h00, 1'b1);
    chk("read_ext", rb, 8'hF4);
    chk("read_oe", {4'h0, oe}, 8'h0D);
    send(8'h82, 1'b0, 8'h00, 1'b0);
    chk("cleared", ext_reg_value, 8'hF0);
  endtask

  task automatic t_dummy;
    logic [87:0] cmds;
    logic [43:0] exps;
    int          v;
    cmds = 88'h0B0D3B6BBBBDEBED4B5A68;
    exps = 44'h88884466888;
    for (int i = 0; i < 15; i++) begin
      quad_command_mode = (i > 10);
      v = n_valid;
      send(i > 10 ? cmds[87-8*(i==12)-48*(i>12)-8*(i==14) -: 8] : cmds[87-8*i -: 8], 1'b0, 8'h00, 1'b0);
      chk("read_valid", 8'(n_valid - v), 8'h01);
      chk("dummy", {4'h0, read_dummy_cycles}, {4'h0, i > 10 ? 4'h6 : exps[43-4*i -: 4]});
    end
    v = n_rej;
    send(8'hBD, 1'b0, 8'h00, 1'b0);
    chk("quad_dual_ddr_refused", 8'(n_rej - v), 8'h01);
    quad_command_mode = 1'b0;
    dummy_field = 4'h5;
    send(8'h0B, 1'b0, 8'h00, 1'b0);
    chk("dummy_explicit", {4'h0, read_dummy_cycles}, 8'h05);
    dummy_field = 4'h0;
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {n_fail, n_checks, n_valid, n_rej, n_nv} = 0;
    {clk_en, rst, quad_command_mode, status_busy, status_locked, soft_reset} = 6'h30;
    {op_done, op_kind, op_fail, op_fail_erase_phase, op_protected, dummy_field} = 11'h000;
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (3) tick;
    t_reset_and_busy;
    t_param_writes;
    t_errors;
    t_sticky_clear;
    t_dummy;
    tally_and_finish;
  end

  initial begin
    #1000000;
    n_fail++;
    tally_and_finish;
  end
endmodule
